// [core/pdsc_pkg.sv]
// Package with the register map, field layout and mode encodings of the pattern detect slice.
package pdsc_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PAT_LO = 8'h04;
  localparam logic [7:0] ADDR_PAT_HI = 8'h08;
  localparam logic [7:0] ADDR_MASK_LO = 8'h0c;
  localparam logic [7:0] ADDR_MASK_HI = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h1c;
  localparam logic [7:0] ADDR_RES_LO = 8'h20;
  localparam logic [7:0] ADDR_RES_HI = 8'h24;

  // Control register field positions.
  localparam int CTRL_MULT_LSB = 0;
  localparam int CTRL_SPLIT_LSB = 2;
  localparam int CTRL_CLEAR_LSB = 4;
  localparam int CTRL_MSRC_LSB = 6;
  localparam int CTRL_PSRC_BIT = 8;
  localparam int CTRL_DETUSE_BIT = 9;
  localparam int CTRL_DEPTH_BIT = 10;
  localparam int CTRL_WIDTH = 11;

  // Status and interrupt bit positions.
  localparam int EVT_HIT_BIT = 0;
  localparam int EVT_LOSS_BIT = 1;
  localparam int EVT_WIDTH = 2;

  // Multiplier usage encodings.
  localparam logic [1:0] MULT_NONE = 2'h0;
  localparam logic [1:0] MULT_ON = 2'h1;
  localparam logic [1:0] MULT_DYN = 2'h2;

  // Adder lane split encodings.
  localparam logic [1:0] SINGLE_WIDE_ADDER = 2'h0;
  localparam logic [1:0] DUAL_HALF_ADDER = 2'h1;
  localparam logic [1:0] QUAD_QUARTER_ADDER = 2'h2;

  // Match auto clear encodings.
  localparam logic [1:0] CLEAR_NONE = 2'h0;
  localparam logic [1:0] CLEAR_HIT = 2'h1;
  localparam logic [1:0] CLEAR_LOSS = 2'h2;

  // Mask source encodings.
  localparam logic [1:0] MSRC_STATIC = 2'h0;
  localparam logic [1:0] MSRC_OPERAND = 2'h1;
  localparam logic [1:0] ROUND_MASK_SHIFT_ONE = 2'h2;
  localparam logic [1:0] ROUND_MASK_SHIFT_TWO = 2'h3;

  // Reset values.
  localparam logic [10:0] CTRL_RESET = 11'h401;
  localparam logic [47:0] PAT_RESET = 48'h0000_0000_0000;
  localparam logic [47:0] MASK_RESET = 48'h3fff_ffff_ffff;

endpackage

// [core/pdsc_match.sv]
// Masked pattern comparator used by the slice on two result values.
module pdsc_match
  import pdsc_pkg::*;
#(
  parameter int WIDTH = 48
)
(
  // Value under test and selected pattern and mask.
  input wire logic [WIDTH-1:0] value_i,
  input wire logic [WIDTH-1:0] pattern_i,
  input wire logic [WIDTH-1:0] mask_i,
  // Match flag.
  output logic hit_o
);

  // Mask bits at one drop a position; all remaining positions must agree.
  assign hit_o = &((~(value_i ^ pattern_i)) | mask_i);

endmodule

// [core/pdsc_slice.sv]
// Arithmetic slice with lane split adder, pattern detector, auto clear and register port.
//
// Design decisions made here: the register addresses and the strobed register port.
module pdsc_slice
  import pdsc_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Operands and per-cycle controls.
  input wire logic [29:0] op_a_i,
  input wire logic [17:0] op_b_i,
  input wire logic [47:0] op_c_i,
  input wire logic mult_sel_i,
  input wire logic accum_i,
  // Results.
  output logic [47:0] p_o,
  output logic match_o,
  output logic match_prev_o,
  output logic irq_o
);

  logic rst_meta_q;
  logic rst_sync_q;
  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic [47:0] pat_q;
  logic [47:0] mask_q;
  logic [EVT_WIDTH-1:0] status_q;
  logic [EVT_WIDTH-1:0] irq_en_q;
  logic [47:0] p_q;
  logic [47:0] p_d;
  logic det_prev_q;
  logic [1:0] mult_use;
  logic [1:0] lane_split;
  logic [1:0] auto_clear;
  logic [1:0] mask_src;
  logic pat_src;
  logic detector_used;
  logic output_stage_depth;
  logic use_product;
  logic signed [42:0] product;
  logic [47:0] x_opnd;
  logic [47:0] y_opnd;
  logic [47:0] sum;
  logic [4:0] carry;
  logic [3:0] lane_cut;
  logic [47:0] pat_sel;
  logic [47:0] mask_sel;
  logic det_reg;
  logic det_next;
  logic clr_hit;
  logic clr_loss;
  logic [EVT_WIDTH-1:0] evt;
  logic [EVT_WIDTH-1:0] clr_bits;

  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Control field extraction.
  assign mult_use = ctrl_q[CTRL_MULT_LSB +: 2];
  assign lane_split = ctrl_q[CTRL_SPLIT_LSB +: 2];
  assign auto_clear = ctrl_q[CTRL_CLEAR_LSB +: 2];
  assign mask_src = ctrl_q[CTRL_MSRC_LSB +: 2];
  assign pat_src = ctrl_q[CTRL_PSRC_BIT];
  // Only reported back to software; the datapath never looks at it.
  assign detector_used = ctrl_q[CTRL_DETUSE_BIT];
  assign output_stage_depth = ctrl_q[CTRL_DEPTH_BIT];

  // Configuration registers written by software.
  always_ff @(posedge mclk_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      ctrl_q <= CTRL_RESET;
      pat_q <= PAT_RESET;
      mask_q <= MASK_RESET;
      irq_en_q <= '0;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        ADDR_CTRL: ctrl_q <= reg_wdata_i[CTRL_WIDTH-1:0];
        ADDR_PAT_LO: pat_q[31:0] <= reg_wdata_i;
        ADDR_PAT_HI: pat_q[47:32] <= reg_wdata_i[15:0];
        ADDR_MASK_LO: mask_q[31:0] <= reg_wdata_i;
        ADDR_MASK_HI: mask_q[47:32] <= reg_wdata_i[15:0];
        ADDR_IRQ_EN: irq_en_q <= reg_wdata_i[EVT_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // Multiplier or bypass concatenation feeds the adder's first input.
  assign use_product = (mult_use == MULT_ON) || ((mult_use == MULT_DYN) && mult_sel_i);
  assign product = $signed(op_a_i[24:0]) * $signed(op_b_i);
  // With usage none the multiplier result is never selected.
  assign x_opnd = use_product ? {{5{product[42]}}, product} : {op_a_i, op_b_i};
  assign y_opnd = accum_i ? p_q : op_c_i;

  // Lane boundaries at bits 12 and 36 open only for four lanes, bit 24 for two or four.
  assign lane_cut[0] = 1'b1;
  assign lane_cut[1] = (lane_split == QUAD_QUARTER_ADDER);
  assign lane_cut[2] = (lane_split != SINGLE_WIDE_ADDER);
  assign lane_cut[3] = (lane_split == QUAD_QUARTER_ADDER);
  assign carry[0] = 1'b0;

  // Four 12-bit segments; a cut boundary drops the incoming carry.
  for (genvar k = 0; k < 4; k++)
  begin : g_lane
    logic cin;
    assign cin = lane_cut[k] ? 1'b0 : carry[k];
    assign {carry[k+1], sum[12*k +: 12]} = {1'b0, x_opnd[12*k +: 12]}
                                          + {1'b0, y_opnd[12*k +: 12]} + {12'h000, cin};
  end

  // Pattern and mask source selection.
  assign pat_sel = pat_src ? op_c_i : pat_q;
  always_comb
  begin
    case (mask_src)
      MSRC_STATIC: mask_sel = mask_q;
      MSRC_OPERAND: mask_sel = op_c_i;
      ROUND_MASK_SHIFT_ONE: mask_sel = {~op_c_i[46:0], 1'b0};
      ROUND_MASK_SHIFT_TWO: mask_sel = {~op_c_i[45:0], 2'b00};
      default: mask_sel = mask_q;
    endcase
  end

  // Detector on the output register and on the value about to be loaded.
  pdsc_match #(.WIDTH(48)) u_det_reg (
    .value_i(p_q),
    .pattern_i(pat_sel),
    .mask_i(mask_sel),
    .hit_o(det_reg)
  );

  pdsc_match #(.WIDTH(48)) u_det_next (
    .value_i(p_d),
    .pattern_i(pat_sel),
    .mask_i(mask_sel),
    .hit_o(det_next)
  );

  // Auto clear conditions judged on the current cycle's detector result.
  assign clr_hit = (auto_clear == CLEAR_HIT) && det_reg;
  assign clr_loss = (auto_clear == CLEAR_LOSS) && !det_reg && det_prev_q;
  assign p_d = (clr_hit || clr_loss) ? 48'h0000_0000_0000 : sum;

  // Output register, zeroed the cycle after an auto clear condition.
  always_ff @(posedge mclk_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      p_q <= '0;
      det_prev_q <= 1'b0;
    end
    else
    begin
      p_q <= p_d;
      det_prev_q <= det_reg;
    end
  end

  // Depth one adds a stage; depth zero shows the output register as it loads.
  always_ff @(posedge mclk_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      p_o <= '0;
      match_o <= 1'b0;
      match_prev_o <= 1'b0;
    end
    else if (output_stage_depth)
    begin
      p_o <= p_q;
      match_o <= det_reg;
      match_prev_o <= det_prev_q;
    end
    else
    begin
      p_o <= p_d;
      match_o <= det_next;
      match_prev_o <= det_reg;
    end
  end

  // Match gained and match lost events; a new event beats a clear in the same cycle.
  assign evt[EVT_HIT_BIT] = det_reg && !det_prev_q;
  assign evt[EVT_LOSS_BIT] = !det_reg && det_prev_q;
  assign clr_bits = (reg_wr_i && (reg_addr_i == ADDR_IRQ_CLR)) ?
                    reg_wdata_i[EVT_WIDTH-1:0] : '0;

  always_ff @(posedge mclk_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      status_q <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      status_q <= (status_q & ~clr_bits) | evt;
      irq_o <= |(((status_q & ~clr_bits) | evt) & irq_en_q);
    end
  end

  // Read data stand the cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge mclk_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      reg_rdata_o <= '0;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_CTRL: reg_rdata_o <= {21'h0, ctrl_q};
        ADDR_PAT_LO: reg_rdata_o <= pat_q[31:0];
        ADDR_PAT_HI: reg_rdata_o <= {16'h0000, pat_q[47:32]};
        ADDR_MASK_LO: reg_rdata_o <= mask_q[31:0];
        ADDR_MASK_HI: reg_rdata_o <= {16'h0000, mask_q[47:32]};
        ADDR_STATUS: reg_rdata_o <= {30'h0, status_q};
        ADDR_IRQ_EN: reg_rdata_o <= {30'h0, irq_en_q};
        ADDR_RES_LO: reg_rdata_o <= p_q[31:0];
        ADDR_RES_HI: reg_rdata_o <= {15'h0000, det_reg, p_q[47:32]};
        default: reg_rdata_o <= '0;
      endcase
    end
    else
    begin
      reg_rdata_o <= '0;
    end
  end

  // Checks on the datapath and detector.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_sync_q);

  a_dyn_bypass: assert property (
    (mult_use == MULT_DYN) && !mult_sel_i |-> x_opnd == {op_a_i, op_b_i})
    else $error("Dynamic bypass did not pass the concatenation.");

  a_none_bypass: assert property (
    (mult_use == MULT_NONE) && mult_sel_i |-> !use_product)
    else $error("Multiplier selected while usage is none.");

  a_single_add: assert property (
    lane_split == SINGLE_WIDE_ADDER |-> sum == 48'(x_opnd + y_opnd))
    else $error("Single wide adder gave a wrong sum.");

  a_lane_isolation: assert property (
    lane_split == QUAD_QUARTER_ADDER |->
      sum[23:12] == 12'(x_opnd[23:12] + y_opnd[23:12]))
    else $error("Carry leaked across a quarter lane boundary.");

  a_half_isolation: assert property (
    lane_split == DUAL_HALF_ADDER |-> sum[47:24] == 24'(x_opnd[47:24] + y_opnd[47:24]))
    else $error("Carry leaked across the half lane boundary.");

  a_clear_on_hit: assert property (
    auto_clear == CLEAR_HIT && det_reg |=> p_q == 48'h0000_0000_0000)
    else $error("Output register not cleared after a match.");

  a_no_clear: assert property (
    auto_clear == CLEAR_NONE |=> p_q == $past(sum))
    else $error("Output register changed without auto clear.");

  a_clear_on_loss: assert property (
    auto_clear == CLEAR_LOSS && $fell(det_reg) |=> p_q == 48'h0000_0000_0000)
    else $error("Output register not cleared after match loss.");

  a_mask_all_ones: assert property (
    mask_sel == 48'hffff_ffff_ffff |-> det_reg)
    else $error("Fully masked compare did not match.");

  a_exact_match: assert property (
    mask_sel == 48'h0000_0000_0000 |-> det_reg == (p_q == pat_sel))
    else $error("Unmasked compare disagrees with equality.");

  a_round_mask: assert property (
    mask_src == ROUND_MASK_SHIFT_TWO |-> mask_sel[1:0] == 2'b00 && mask_sel[2] == !op_c_i[0])
    else $error("Second rounding mask is malformed.");

  a_output_depth: assert property (
    output_stage_depth |=> p_o == $past(p_q) && match_o == $past(det_reg))
    else $error("Output stage did not delay result and match together.");

  c_hit_clear: cover property (auto_clear == CLEAR_HIT && det_reg ##1 p_q == 48'h0);
  c_loss_clear: cover property (auto_clear == CLEAR_LOSS && $fell(det_reg));
  c_quad_lanes: cover property (lane_split == QUAD_QUARTER_ADDER && carry[1]);
  c_irq_raise: cover property (!irq_o ##1 irq_o);

endmodule

// [sim/pdsc_fabric.sv]
// Fabric-side model that presents operands and per-cycle controls to the slice.
module pdsc_fabric
(
  // Operands and per-cycle controls.
  output logic [29:0] op_a_o,
  output logic [17:0] op_b_o,
  output logic [47:0] op_c_o,
  output logic mult_sel_o,
  output logic accum_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Operands start at zero so nothing unknown reaches the adder.
  initial
  begin
    op_a_o = '0;
    op_b_o = '0;
    op_c_o = '0;
    mult_sel_o = 1'b0;
    accum_o = 1'b0;
  end

  // Called just after a rising edge; the values hold until the next call.
  task automatic put(input logic [29:0] a, input logic [17:0] b, input logic [47:0] c,
    input logic sel, input logic acc);
    op_a_o <= a;
    op_b_o <= b;
    op_c_o <= c;
    mult_sel_o <= sel;
    accum_o <= acc;
  endtask
endmodule

// [sim/test_dsp_pattern_detect_simd_config.sv]
// Self-checking bench for the pattern detect slice.
module test_dsp_pattern_detect_simd_config;
  import pdsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [10:0] ctrl;
    logic [29:0] a;
    logic [17:0] b;
    logic [47:0] c;
    logic sel;
    logic [47:0] p;
    logic m;
  } pdsc_row_type;

  logic mclk_i;
  logic rst_n_i;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic [29:0] op_a_i;
  logic [17:0] op_b_i;
  logic [47:0] op_c_i;
  logic mult_sel_i;
  logic accum_i;
  logic [47:0] p_o;
  logic match_o;
  logic match_prev_o;
  logic irq_o;
  logic [31:0] rdv;
  int mismatches = 0;
  int total_checks = 0;
  logic [7:0] ra [6] = '{ADDR_CTRL, ADDR_PAT_LO, ADDR_MASK_LO, ADDR_MASK_HI, ADDR_IRQ_EN, 8'h40};
  logic [31:0] rv [6] = '{32'h401, 32'h0, 32'hffff_ffff, 32'h3fff, 32'h0, 32'h0};
  // Static mask compares the low byte; static pattern is 0x22.
  pdsc_row_type rows [16] = '{
    '{11'h401, 30'h3, 18'h5, 48'h13, 1'b0, 48'h22, 1'b1},
    '{11'h401, 30'h3fff_fffe, 18'h3, 48'h0, 1'b0, 48'hffff_ffff_fffa, 1'b0},
    '{11'h400, 30'h1, 18'h2, 48'h20, 1'b0, 48'h4_0022, 1'b1},
    '{11'h402, 30'h3, 18'h5, 48'h0, 1'b1, 48'hf, 1'b0},
    '{11'h402, 30'h3, 18'h5, 48'h0, 1'b0, 48'hc_0005, 1'b0},
    '{11'h404, 30'h3f, 18'h3_ffff, 48'h1, 1'b0, 48'h0, 1'b0},
    '{11'h408, 30'h0, 18'hfff, 48'h1, 1'b0, 48'h0, 1'b0},
    '{11'h400, 30'h0, 18'hfff, 48'h1, 1'b0, 48'h1000, 1'b0},
    '{11'h440, 30'h0, 18'h122, 48'hffff_ffff_ff00, 1'b0, 48'h22, 1'b1},
    '{11'h500, 30'h0, 18'h0, 48'h77, 1'b0, 48'h77, 1'b1},
    '{11'h480, 30'h0, 18'h1, 48'h1, 1'b0, 48'h2, 1'b1},
    '{11'h4c0, 30'h0, 18'h5, 48'h1, 1'b0, 48'h6, 1'b0},
    '{11'h601, 30'h3, 18'h5, 48'h13, 1'b0, 48'h22, 1'b1},
    '{11'h540, 30'h0, 18'h0, 48'h0, 1'b0, 48'h0, 1'b1},
    '{11'h540, 30'h0, 18'h100, 48'h0, 1'b0, 48'h100, 1'b0},
    '{11'h440, 30'h0, 18'h11, 48'hffff_ffff_ffff, 1'b0, 48'h10, 1'b1}
  };

  pdsc_slice dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .op_a_i(op_a_i), .op_b_i(op_b_i), .op_c_i(op_c_i),
    .mult_sel_i(mult_sel_i), .accum_i(accum_i), .p_o(p_o), .match_o(match_o),
    .match_prev_o(match_prev_o), .irq_o(irq_o));

  pdsc_fabric fab (.op_a_o(op_a_i), .op_b_o(op_b_i), .op_c_o(op_c_i),
    .mult_sel_o(mult_sel_i), .accum_o(accum_i));

  // Free-running 200 MHz clock.
  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  // One-cycle read strobe; data is taken in the cycle after it.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // Accumulates 0x11 per cycle from zero and checks the result five edges later.
  task automatic acc_run(input logic [10:0] ctrl, input logic [47:0] exp);
    wr(ADDR_CTRL, {21'h0, ctrl});
    fab.put('0, '0, '0, 1'b0, 1'b0);
    @(posedge mclk_i);
    fab.put('0, 18'h11, '0, 1'b0, 1'b1);
    repeat (5) @(posedge mclk_i);
    #1;
    check(p_o, exp);
    $display("auto clear test ctrl=%h done", ctrl);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Cuts a hang short well after the expected run length.
  initial
  begin
    #20000;
    mismatches++;
    test_done();
  end

  // Main sequence.
  initial
  begin
    rst_n_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    for (int i = 0; i < 6; i++)
    begin
      rd(ra[i], rdv);
      check({16'h0, rdv}, {16'h0, rv[i]});
    end
    check(p_o, 48'h0);
    $display("reset test done");
    wr(ADDR_MASK_LO, 32'hffff_ff00);
    wr(ADDR_MASK_HI, 32'hffff);
    wr(ADDR_PAT_LO, 32'h22);
    foreach (rows[i])
    begin
      wr(ADDR_CTRL, {21'h0, rows[i].ctrl});
      fab.put(rows[i].a, rows[i].b, rows[i].c, rows[i].sel, 1'b0);
      repeat (2) @(posedge mclk_i);
      #1;
      check(p_o, rows[i].p);
      check({47'h0, match_o}, {47'h0, rows[i].m});
    end
    $display("row test done");
    acc_run(11'h400, 48'h44);
    acc_run(11'h410, 48'h11);
    acc_run(11'h420, 48'h0);
    wr(ADDR_CTRL, 32'h400);
    fab.put('0, '0, '0, 1'b0, 1'b0);
    wr(ADDR_IRQ_EN, 32'h1);
    wr(ADDR_IRQ_CLR, 32'h3);
    wr(ADDR_STATUS, 32'h3);
    rd(ADDR_STATUS, rdv);
    check({16'h0, rdv}, 48'h0);
    check({47'h0, irq_o}, 48'h0);
    @(posedge mclk_i);
    fab.put('0, '0, 48'h22, 1'b0, 1'b0);
    repeat (4) @(posedge mclk_i);
    #1;
    check({47'h0, irq_o}, 48'h1);
    rd(ADDR_STATUS, rdv);
    check({16'h0, rdv}, 48'h1);
    wr(ADDR_IRQ_EN, 32'h0);
    @(posedge mclk_i);
    #1;
    check({47'h0, irq_o}, 48'h0);
    wr(ADDR_IRQ_EN, 32'h1);
    @(posedge mclk_i);
    #1;
    check({47'h0, irq_o}, 48'h1);
    wr(ADDR_IRQ_CLR, 32'h1);
    @(posedge mclk_i);
    #1;
    check({47'h0, irq_o}, 48'h0);
    rd(ADDR_IRQ_CLR, rdv);
    check({16'h0, rdv}, 48'h0);
    // The match loss event lands on the same edge as a clear of both bits and must win.
    @(posedge mclk_i);
    fab.put('0, '0, '0, 1'b0, 1'b0);
    wr(ADDR_IRQ_CLR, 32'h3);
    rd(ADDR_STATUS, rdv);
    check({16'h0, rdv}, 48'h2);
    check({47'h0, irq_o}, 48'h0);
    $display("interrupt test done");
    // Changing operands tell depth zero apart from depth one.
    wr(ADDR_CTRL, 32'h0);
    fab.put('0, '0, 48'h33, 1'b0, 1'b0);
    @(posedge mclk_i);
    #1;
    check(p_o, 48'h33);
    check({47'h0, match_o}, 48'h0);
    fab.put('0, '0, 48'h22, 1'b0, 1'b0);
    @(posedge mclk_i);
    #1;
    check(p_o, 48'h22);
    check({47'h0, match_o}, 48'h1);
    check({47'h0, match_prev_o}, 48'h0);
    rd(ADDR_RES_LO, rdv);
    check({16'h0, rdv}, 48'h22);
    rd(ADDR_RES_HI, rdv);
    check({16'h0, rdv}, 48'h1_0000);
    fab.put('0, '0, 48'h44, 1'b0, 1'b0);
    @(posedge mclk_i);
    #1;
    check(p_o, 48'h44);
    check({47'h0, match_o}, 48'h0);
    check({47'h0, match_prev_o}, 48'h1);
    $display("depth zero test done");
    test_done();
  end
endmodule
